// ### core/awtc_pkg.sv
// constants, field layouts and carrier types of the word trap and capture block
// assumes a single 125 MHz clock and an AHB-Lite register bus
package awtc_pkg;
  localparam int AWTC_CLK_NS = 8;
  localparam int AWTC_MS_NS = 1000000;
  localparam int AWTC_MS_CYC = AWTC_MS_NS / AWTC_CLK_NS;
  localparam int AWTC_REFRESH_MS = 1000 / 4;
  localparam int AWTC_SLEEP_MIN = 5;
  localparam int AWTC_SLEEP_MS = AWTC_SLEEP_MIN * 60000;
  localparam int AWTC_DUMPFAIL_S = 2;
  localparam int AWTC_DUMPFAIL_MS = AWTC_DUMPFAIL_S * 1000;
  localparam int AWTC_LOBIT_NS = 80000;
  localparam int AWTC_GAP_CYC = (4 * AWTC_LOBIT_NS) / AWTC_CLK_NS;
  localparam int AWTC_NORM_DEPTH = 255;
  localparam int AWTC_DO_DEPTH = 511;
  localparam int AWTC_SLOTS = 10;
  localparam logic [15:0] AWTC_RATE_MIN = 16'h0004;
  localparam logic [15:0] AWTC_RATE_MAX = 16'hEA5E;
  localparam logic [23:0] AWTC_MASK_RST = 24'h000003;
  localparam logic [1:0] AWTC_MODE_NORMAL = 2'h0;
  localparam logic [1:0] AWTC_MODE_FILTER = 2'h1;
  localparam logic [1:0] AWTC_MODE_TRAP = 2'h2;
  localparam logic [7:0] AWTC_OFF_CTRL = 8'h00;
  localparam logic [7:0] AWTC_OFF_WORD_FILTER_KEY = 8'h04;
  localparam logic [7:0] AWTC_OFF_TRIGL = 8'h08;
  localparam logic [7:0] AWTC_OFF_TRIGD = 8'h0C;
  localparam logic [7:0] AWTC_OFF_TRIGM = 8'h10;
  localparam logic [7:0] AWTC_OFF_TFLTL = 8'h14;
  localparam logic [7:0] AWTC_OFF_TFLTD = 8'h18;
  localparam logic [7:0] AWTC_OFF_TFLTM = 8'h1C;
  localparam logic [7:0] AWTC_OFF_STAT = 8'h20;
  localparam logic [7:0] AWTC_OFF_CMD = 8'h24;
  localparam logic [7:0] AWTC_OFF_SLOTEN = 8'h28;
  localparam logic [7:0] AWTC_OFF_RDIDX = 8'h2C;
  localparam logic [7:0] AWTC_OFF_RDDATA = 8'h30;
  localparam logic [7:0] AWTC_OFF_RDRATE = 8'h34;
  localparam logic [7:0] AWTC_OFF_DISP = 8'h38;
  localparam logic [1:0] AWTC_SLOT_PAGE = 2'h1;

  typedef struct packed {
    logic txView;
    logic txOdd;
    logic txHigh;
    logic rxHigh;
    logic singleLabel;
    logic [1:0] mode;
  } awtc_ctrl_type;

  typedef struct packed {
    logic [23:0] mask;
    logic [23:0] pattern;
    logic [7:0] label;
    logic dataAny;
    logic labelAny;
  } awtc_spec_type;
endpackage

// ### core/awtc_core.sv
// receive capture, filter and trap engine with transmit slot timing
// assumes an AHB-Lite master, decoded received words and an external serialiser
module awtc_core import awtc_pkg::*; #(
  parameter int MS_CYC = AWTC_MS_CYC,
  parameter int SLEEP_MS = AWTC_SLEEP_MS,
  parameter int GAP_CYC = AWTC_GAP_CYC
) (
  input wire logic core_clk,
  input wire logic reset,
  input wire logic hsel,
  input wire logic [31:0] haddr,
  input wire logic [1:0] htrans,
  input wire logic hwrite,
  input wire logic [2:0] hsize,
  input wire logic [31:0] hwdata,
  input wire logic hready,
  output logic hreadyout,
  output logic hresp,
  output logic [31:0] hrdata,
  input wire logic [31:0] rxWord,
  input wire logic rxValid,
  input wire logic keyPress,
  input wire logic printerReady,
  input wire logic [31:0] txRawWord,
  output logic txStart,
  output logic [3:0] txSlot,
  output logic [31:0] txWord,
  output logic txHighSpeed,
  output logic rxHighSpeed,
  output logic parityOdd,
  output logic asleep,
  output logic dumpStart,
  output logic dumpFailInd
);

  function automatic logic specHit(input awtc_spec_type s, input logic [31:0] w);
    logic lblOk;
    logic datOk;
    lblOk = s.labelAny | (w[7:0] == s.label);
    datOk = s.dataAny | (((w[31:8] ^ s.pattern) & s.mask) == 24'h000000);
    return lblOk & datOk;
  endfunction

  ////////////////////////////////////////////////////////////////////////////
  awtc_ctrl_type ctrl_ff;
  awtc_spec_type trig_ff, tflt_ff, tfltEff;
  logic [7:0] fltLabel_ff;
  logic [1:0] fltSdi_ff;
  logic fltLabelAny_ff, fltSdiAny_ff;
  logic [9:0] slotEn_ff;
  logic [15:0] slotRate_ff [AWTC_SLOTS];
  logic [8:0] rdIdx_ff;
  logic wrEn_ff;
  logic [7:0] wrAddr_ff;
  logic [31:0] hrdata_ff, rdNext;
  logic [31:0] trapMem [AWTC_DO_DEPTH];
  logic [15:0] rateMem [AWTC_NORM_DEPTH];
  logic [31:0] labelMem [256];
  logic [255:0] seen_ff;
  logic [8:0] labelCount_ff;
  logic [9:0] count_ff;
  logic triggered_ff, tlabelSet_ff;
  logic [15:0] msSince_ff;
  logic [16:0] msDiv_ff;
  logic [7:0] refMs_ff;
  logic [31:0] dispWord_ff;
  logic parity_ff;
  logic [18:0] idleMs_ff;
  logic asleep_ff;
  logic [10:0] failMs_ff;
  logic dump_ff, fail_ff;
  logic [15:0] slotCnt_ff [AWTC_SLOTS];
  logic [9:0] pend_ff;
  logic [15:0] gapCnt_ff;
  logic txStart_ff;
  logic [3:0] txSlot_ff;
  logic [31:0] txWord_ff;

  default clocking @(posedge core_clk); endclocking
  default disable iff (reset);

  ////////////////////////////////////////////////////////////////////////////
  // bus slave: zero wait, always OKAY
  wire aphase = hsel & hready & htrans[1];
  wire wrCtrl = wrEn_ff & (wrAddr_ff == AWTC_OFF_CTRL);
  wire wrFilt = wrEn_ff & (wrAddr_ff == AWTC_OFF_WORD_FILTER_KEY);
  wire wrTrigL = wrEn_ff & (wrAddr_ff == AWTC_OFF_TRIGL);
  wire wrTrigD = wrEn_ff & (wrAddr_ff == AWTC_OFF_TRIGD);
  wire wrTrigM = wrEn_ff & (wrAddr_ff == AWTC_OFF_TRIGM);
  wire wrTfltL = wrEn_ff & (wrAddr_ff == AWTC_OFF_TFLTL);
  wire wrTfltD = wrEn_ff & (wrAddr_ff == AWTC_OFF_TFLTD);
  wire wrTfltM = wrEn_ff & (wrAddr_ff == AWTC_OFF_TFLTM);
  wire wrCmd = wrEn_ff & (wrAddr_ff == AWTC_OFF_CMD);
  wire wrSlotEn = wrEn_ff & (wrAddr_ff == AWTC_OFF_SLOTEN);
  wire wrRdIdx = wrEn_ff & (wrAddr_ff == AWTC_OFF_RDIDX);
  wire wrSlotPg = wrEn_ff & (wrAddr_ff[7:6] == AWTC_SLOT_PAGE);
  wire [3:0] wrSlotIdx = wrAddr_ff[5:2];
  wire awtc_ctrl_type newCtrl = awtc_ctrl_type'(hwdata[6:0]);
  wire trapMode = ctrl_ff.mode == AWTC_MODE_TRAP;
  wire ctrlOk = newCtrl.mode != 2'h3;
  wire enterTrap = ~trapMode & (newCtrl.mode == AWTC_MODE_TRAP);
  wire singleOk = enterTrap | (trapMode & (count_ff == 10'h000) & ~tlabelSet_ff);
  wire leaveTrap = wrCtrl & ctrlOk & trapMode & (newCtrl.mode != AWTC_MODE_TRAP);
  wire [15:0] newRate = hwdata[15:0];
  wire rateOk = (newRate >= AWTC_RATE_MIN) & (newRate <= AWTC_RATE_MAX);
  wire resync = wrCmd & hwdata[0] & ctrl_ff.txView;
  wire dumpReq = wrCmd & hwdata[1] & trapMode & (count_ff != 10'h000);

  assign hreadyout = 1'b1;
  assign hresp = 1'b0;
  assign hrdata = hrdata_ff;

  always_comb begin
    rdNext = 32'h00000000;
    case (haddr[7:0])
      AWTC_OFF_CTRL: rdNext = {25'h0, ctrl_ff};
      AWTC_OFF_WORD_FILTER_KEY: rdNext = {20'h0, fltSdiAny_ff, fltLabelAny_ff, fltSdi_ff, fltLabel_ff};
      AWTC_OFF_TRIGL: rdNext = {22'h0, trig_ff.dataAny, trig_ff.labelAny, trig_ff.label};
      AWTC_OFF_TRIGD: rdNext = {8'h00, trig_ff.pattern};
      AWTC_OFF_TRIGM: rdNext = {8'h00, trig_ff.mask};
      AWTC_OFF_TFLTL: rdNext = {22'h0, tflt_ff.dataAny, tflt_ff.labelAny, tflt_ff.label};
      AWTC_OFF_TFLTD: rdNext = {8'h00, tflt_ff.pattern};
      AWTC_OFF_TFLTM: rdNext = {8'h00, tflt_ff.mask};
      AWTC_OFF_STAT: rdNext = {18'h0, fail_ff, parity_ff, asleep_ff, triggered_ff,
                               trapMode ? count_ff : {1'b0, labelCount_ff}};
      AWTC_OFF_SLOTEN: rdNext = {22'h0, slotEn_ff};
      AWTC_OFF_RDIDX: rdNext = {23'h0, rdIdx_ff};
      AWTC_OFF_RDDATA: rdNext = trapMode ? trapMem[rdIdx_ff] : labelMem[rdIdx_ff[7:0]];
      AWTC_OFF_RDRATE: rdNext = (trapMode & ~ctrl_ff.singleLabel & (rdIdx_ff[8] == 1'b0))
                                ? {16'h0, rateMem[rdIdx_ff[7:0]]} : 32'h00000000;
      AWTC_OFF_DISP: rdNext = dispWord_ff;
      default: begin
        if (haddr[7:6] == AWTC_SLOT_PAGE && haddr[5:2] < 4'(AWTC_SLOTS)) begin
          rdNext = {16'h0, slotRate_ff[haddr[5:2]]};
        end
      end
    endcase
  end

  always_ff @(posedge core_clk or posedge reset) begin
    if (reset) begin
      wrEn_ff <= 1'b0;
      wrAddr_ff <= 8'h00;
      hrdata_ff <= 32'h00000000;
    end else begin
      wrEn_ff <= aphase & hwrite;
      if (aphase) begin
        wrAddr_ff <= haddr[7:0];
        hrdata_ff <= rdNext;
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // settings registers
  always_ff @(posedge core_clk or posedge reset) begin
    if (reset) begin
      ctrl_ff <= '0;
      trig_ff <= '{mask: AWTC_MASK_RST, pattern: 24'h0, label: 8'h00, dataAny: 1'b1, labelAny: 1'b1};
      tflt_ff <= '{mask: AWTC_MASK_RST, pattern: 24'h0, label: 8'h00, dataAny: 1'b1, labelAny: 1'b1};
      fltLabel_ff <= 8'h00;
      fltSdi_ff <= 2'h0;
      fltLabelAny_ff <= 1'b1;
      fltSdiAny_ff <= 1'b1;
      slotEn_ff <= 10'h000;
      rdIdx_ff <= 9'h000;
      tlabelSet_ff <= 1'b0;
    end else begin
      if (wrCtrl && ctrlOk) begin
        ctrl_ff <= newCtrl;
        ctrl_ff.singleLabel <= (newCtrl.mode == AWTC_MODE_TRAP) &
                               (singleOk ? newCtrl.singleLabel : ctrl_ff.singleLabel);
      end
      if (leaveTrap) begin
        tlabelSet_ff <= 1'b0;
      end else if (wrTfltL && trapMode) begin
        tlabelSet_ff <= 1'b1;
      end
      if (wrFilt) begin
        {fltSdiAny_ff, fltLabelAny_ff, fltSdi_ff, fltLabel_ff} <= hwdata[11:0];
      end
      if (wrTrigL) begin
        {trig_ff.dataAny, trig_ff.labelAny, trig_ff.label} <= hwdata[9:0];
      end
      if (wrTrigD) trig_ff.pattern <= hwdata[23:0];
      if (wrTrigM) trig_ff.mask <= hwdata[23:0];
      if (wrTfltL) begin
        {tflt_ff.dataAny, tflt_ff.labelAny, tflt_ff.label} <= hwdata[9:0];
      end
      if (wrTfltD) tflt_ff.pattern <= hwdata[23:0];
      if (wrTfltM) tflt_ff.mask <= hwdata[23:0];
      if (wrSlotEn) slotEn_ff <= hwdata[9:0];
      if (wrRdIdx) rdIdx_ff <= hwdata[8:0];
    end
  end

  assign txHighSpeed = ctrl_ff.txHigh;
  assign rxHighSpeed = ctrl_ff.rxHigh;

  ////////////////////////////////////////////////////////////////////////////
  // millisecond and refresh ticks
  wire msTick = msDiv_ff == 17'(MS_CYC - 1);
  wire refTick = msTick & (refMs_ff == 8'(AWTC_REFRESH_MS - 1));

  always_ff @(posedge core_clk or posedge reset) begin
    if (reset) begin
      msDiv_ff <= 17'h00000;
      refMs_ff <= 8'h00;
    end else begin
      msDiv_ff <= msTick ? 17'h00000 : msDiv_ff + 17'h00001;
      if (refTick) refMs_ff <= 8'h00;
      else if (msTick) refMs_ff <= refMs_ff + 8'h01;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // normal and filter capture
  wire [7:0] rxLabel = rxWord[7:0];
  wire fltHit = (fltLabelAny_ff | (rxLabel == fltLabel_ff)) &
                (fltSdiAny_ff | (rxWord[9:8] == fltSdi_ff));
  wire liveKeep = rxValid & ((ctrl_ff.mode == AWTC_MODE_NORMAL) |
                             ((ctrl_ff.mode == AWTC_MODE_FILTER) & fltHit));

  always_ff @(posedge core_clk) begin
    if (liveKeep) labelMem[rxLabel] <= rxWord;
  end

  always_ff @(posedge core_clk or posedge reset) begin
    if (reset) begin
      seen_ff <= '0;
      labelCount_ff <= 9'h000;
    end else if (liveKeep && !seen_ff[rxLabel]) begin
      seen_ff[rxLabel] <= 1'b1;
      labelCount_ff <= labelCount_ff + 9'h001;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // trap capture
  always_comb begin
    tfltEff = tflt_ff;
    if (ctrl_ff.singleLabel) tfltEff.labelAny = 1'b0;
  end

  wire trigNone = trig_ff.labelAny & trig_ff.dataAny;
  wire armed = triggered_ff | trigNone | specHit(trig_ff, rxWord);
  wire [9:0] capLimit = ctrl_ff.singleLabel ? 10'(AWTC_DO_DEPTH) : 10'(AWTC_NORM_DEPTH);
  wire doCapture = rxValid & trapMode & armed & specHit(tfltEff, rxWord) &
                   (count_ff < capLimit);

  // capture arrays (trapMem, rateMem, labelMem) keep no reset so contents outlive a core reset
  always_ff @(posedge core_clk) begin
    if (doCapture) begin
      trapMem[count_ff[8:0]] <= ctrl_ff.singleLabel ? {rxWord[31:8], 8'h00} : rxWord;
      if (!ctrl_ff.singleLabel) rateMem[count_ff[7:0]] <= msSince_ff;
    end
  end

  always_ff @(posedge core_clk or posedge reset) begin
    if (reset) begin
      count_ff <= 10'h000;
      triggered_ff <= 1'b0;
      msSince_ff <= 16'h0000;
    end else begin
      if (leaveTrap) begin
        count_ff <= 10'h000;
        triggered_ff <= 1'b0;
      end else begin
        if (doCapture) count_ff <= count_ff + 10'h001;
        if (rxValid && trapMode && armed) triggered_ff <= 1'b1;
      end
      if (doCapture) msSince_ff <= 16'h0000;
      else if (msTick && msSince_ff != 16'hFFFF) msSince_ff <= msSince_ff + 16'h0001;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // presented word and parity indicator
  always_ff @(posedge core_clk or posedge reset) begin
    if (reset) begin
      dispWord_ff <= 32'h00000000;
      parity_ff <= 1'b0;
    end else begin
      if (refTick) dispWord_ff <= trapMode ? trapMem[rdIdx_ff] : labelMem[rdIdx_ff[7:0]];
      parity_ff <= ctrl_ff.txView ? ctrl_ff.txOdd : ^dispWord_ff;
    end
  end

  assign parityOdd = parity_ff;

  ////////////////////////////////////////////////////////////////////////////
  // sleep timer
  always_ff @(posedge core_clk or posedge reset) begin
    if (reset) begin
      idleMs_ff <= 19'h00000;
      asleep_ff <= 1'b0;
    end else begin
      if (keyPress || rxValid || txStart_ff) idleMs_ff <= 19'h00000;
      else if (msTick && idleMs_ff != 19'(SLEEP_MS)) idleMs_ff <= idleMs_ff + 19'h00001;
      if (keyPress || rxValid) asleep_ff <= 1'b0;
      else if (idleMs_ff == 19'(SLEEP_MS)) asleep_ff <= 1'b1;
    end
  end

  assign asleep = asleep_ff;

  ////////////////////////////////////////////////////////////////////////////
  // printer dump request
  always_ff @(posedge core_clk or posedge reset) begin
    if (reset) begin
      dump_ff <= 1'b0;
      fail_ff <= 1'b0;
      failMs_ff <= 11'h000;
    end else begin
      dump_ff <= dumpReq & printerReady;
      if (dumpReq && !printerReady) begin
        failMs_ff <= 11'(AWTC_DUMPFAIL_MS);
        fail_ff <= 1'b1;
      end else if (msTick && failMs_ff != 11'h000) begin
        failMs_ff <= failMs_ff - 11'h001;
        fail_ff <= failMs_ff != 11'h001;
      end
    end
  end

  assign dumpStart = dump_ff;
  assign dumpFailInd = fail_ff;

  ////////////////////////////////////////////////////////////////////////////
  // transmit slot timers and arbiter
  logic [3:0] pick;
  wire gapDone = gapCnt_ff == 16'h0000;
  wire grant = gapDone & (pend_ff != 10'h000);

  always_comb begin
    pick = 4'h0;
    for (int k = 0; k < AWTC_SLOTS; k++) begin
      if (pend_ff[k]) pick = 4'(k);
    end
  end

  for (genvar i = 0; i < AWTC_SLOTS; i++) begin : g_slot
    wire expire = msTick & slotEn_ff[i] & (slotCnt_ff[i] <= 16'h0001);
    always_ff @(posedge core_clk or posedge reset) begin
      if (reset) begin
        slotRate_ff[i] <= AWTC_RATE_MIN;
        slotCnt_ff[i] <= AWTC_RATE_MIN;
        pend_ff[i] <= 1'b0;
      end else begin
        if (wrSlotPg && wrSlotIdx == 4'(i) && rateOk) slotRate_ff[i] <= newRate;
        if (resync || !slotEn_ff[i] || expire) slotCnt_ff[i] <= slotRate_ff[i];
        else if (msTick) slotCnt_ff[i] <= slotCnt_ff[i] - 16'h0001;
        if (resync || !slotEn_ff[i]) pend_ff[i] <= 1'b0;
        else if (expire) pend_ff[i] <= 1'b1;
        else if (grant && pick == 4'(i)) pend_ff[i] <= 1'b0;
      end
    end
  end

  always_ff @(posedge core_clk or posedge reset) begin
    if (reset) begin
      gapCnt_ff <= 16'h0000;
      txStart_ff <= 1'b0;
      txSlot_ff <= 4'h0;
      txWord_ff <= 32'h00000000;
    end else begin
      txStart_ff <= grant;
      if (grant) begin
        gapCnt_ff <= 16'(GAP_CYC);
        txSlot_ff <= pick;
        txWord_ff <= {ctrl_ff.txOdd ^ (^txRawWord[30:0]), txRawWord[30:0]};
      end else if (!gapDone) begin
        gapCnt_ff <= gapCnt_ff - 16'h0001;
      end
    end
  end

  assign txStart = txStart_ff;
  assign txSlot = txSlot_ff;
  assign txWord = txWord_ff;

  ////////////////////////////////////////////////////////////////////////////
  sequence s_leave;
    leaveTrap;
  endsequence
  sequence s_cleared;
    (count_ff == 10'h000) && !ctrl_ff.singleLabel;
  endsequence

  a_mode_legal: assert property (ctrl_ff.mode != 2'h3) else $error("illegal mode held");
  a_trap_cap: assert property (!ctrl_ff.singleLabel |-> count_ff <= 10'(AWTC_NORM_DEPTH))
    else $error("trap count over 255");
  a_single_cap: assert property (count_ff <= 10'(AWTC_DO_DEPTH)) else $error("trap count over 511");
  a_capture_step: assert property (doCapture && !leaveTrap |=> count_ff == $past(count_ff) + 10'h001)
    else $error("capture did not advance");
  a_trigger_wait: assert property (rxValid && trapMode && !armed && !leaveTrap |=> $stable(count_ff))
    else $error("capture before trigger");
  a_trap_clear: assert property (s_leave |=> s_cleared) else $error("trap off left state");
  a_tx_gap: assert property (txStart |=> !txStart [*2] ##0 (gapCnt_ff == 16'(GAP_CYC - 2)))
    else $error("transmit gap too short");
  a_resync_clear: assert property (resync |=> pend_ff == 10'h000) else $error("resync left pending");
  a_wake_up: assert property (asleep_ff && keyPress |=> !asleep_ff) else $error("no wake on key");
  a_dump_fail: assert property (dumpReq && !printerReady |=> fail_ff && !dump_ff)
    else $error("dump failure not shown");
  a_tx_parity: assert property (ctrl_ff.txView && $stable(ctrl_ff) |=> parity_ff == $past(ctrl_ff.txOdd))
    else $error("tx parity indicator wrong");

endmodule

// ### tb/awtc_uut_model.sv
// stand-in for the unit under test that sends words to the receiver
// assumes the bench calls send_word just after a rising edge
module awtc_uut_model (
  input wire logic core_clk,
  output logic [31:0] rxWord,
  output logic rxValid
);
  timeunit 1ns;
  timeprecision 1ps;
  initial begin
    rxWord = 32'h5A5A_5A5A;
    rxValid = 1'b0;
  end
  // one word per call, then the lines show the inverse of the word
  task automatic send_word(input logic [31:0] w);
    rxWord <= w;
    rxValid <= 1'b1;
    @(posedge core_clk);
    rxWord <= ~w;
    rxValid <= 1'b0;
    @(posedge core_clk);
  endtask
endmodule

// ### tb/arinc_word_trap_capture_tb_top.sv
// self-checking bench for the word trap and capture core
// assumes register offsets of awtc_pkg and the far-side stand-in
module arinc_word_trap_capture_tb_top import awtc_pkg::*;;
  timeunit 1ns;
  timeprecision 1ps;
  localparam int GAP = 8;
  logic core_clk, reset, hsel, hwrite, hreadyout, rxValid, keyPress, printerReady;
  logic txStart, txHighSpeed, rxHighSpeed, parityOdd, asleep, dumpStart, dumpFailInd;
  logic [1:0] htrans;
  logic [3:0] txSlot;
  logic [31:0] haddr, hwdata, hrdata, rxWord, txRawWord, txWord;
  int n_mismatch = 0;
  int tests_run = 0;
  int n;
  awtc_core #(.MS_CYC(16), .SLEEP_MS(5), .GAP_CYC(GAP)) i_dut (.core_clk(core_clk), .reset(reset),
    .hsel(hsel), .haddr(haddr), .htrans(htrans), .hwrite(hwrite), .hsize(3'h2), .hwdata(hwdata),
    .hready(hreadyout), .hreadyout(hreadyout), .hresp(), .hrdata(hrdata), .rxWord(rxWord),
    .rxValid(rxValid), .keyPress(keyPress), .printerReady(printerReady), .txRawWord(txRawWord),
    .txStart(txStart), .txSlot(txSlot), .txWord(txWord), .txHighSpeed(txHighSpeed),
    .rxHighSpeed(rxHighSpeed), .parityOdd(parityOdd), .asleep(asleep), .dumpStart(dumpStart),
    .dumpFailInd(dumpFailInd));
  awtc_uut_model i_uut (.core_clk(core_clk), .rxWord(rxWord), .rxValid(rxValid));
  ////////////////////////////////////////////////////////////////////////
  task automatic tally_and_finish;
    $display("compares %0d mismatches %0d", tests_run, n_mismatch);
    if (n_mismatch == 0 && tests_run > 0)
      $display("bench passed");
    else
      $display("bench failed");
    $finish;
  endtask
  task automatic hang;
    n_mismatch++;
    $display("ERROR %0t wait limit reached", $time);
    tally_and_finish();
  endtask
  task automatic check(input logic [31:0] seen, input logic [31:0] exp);
    tests_run++;
    if (seen !== exp) begin
      n_mismatch++;
      $display("ERROR %0t seen %h expected %h", $time, seen, exp);
    end
  endtask
  task automatic wait_rdy;
    int k;
    k = 0;
    do begin
      @(posedge core_clk);
      k++;
    end while (hreadyout !== 1'b1 && k < 100);
    if (k >= 100) hang();
  endtask
  // address phase held until hready, then data phase until hready
  task automatic bus(input logic wr, input logic [7:0] a, input logic [31:0] wd, output logic [31:0] rd);
    hsel <= 1'b1;
    htrans <= 2'h2;
    haddr <= {24'h000000, a};
    hwrite <= wr;
    wait_rdy();
    hsel <= 1'b0;
    htrans <= 2'h0;
    hwdata <= wd;
    wait_rdy();
    rd = hrdata;
  endtask
  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    logic [31:0] x;
    bus(1'b1, a, d, x);
  endtask
  task automatic rchk(input logic [7:0] a, input logic [31:0] m, input logic [31:0] e);
    logic [31:0] x;
    bus(1'b0, a, 32'h0000_0000, x);
    check(x & m, e);
  endtask
  task automatic send_n(input logic [31:0] w, input int cnt);
    repeat (cnt) i_uut.send_word(w);
  endtask
  // 0 tx start, 1 asleep, 2 awake, 3 dump start, other dump fail
  task automatic wait_for(input int which, output int k);
    logic hit;
    k = 0;
    hit = 1'b0;
    while (!hit) begin
      @(posedge core_clk);
      k++;
      case (which)
        0: hit = (txStart === 1'b1);
        1: hit = (asleep === 1'b1);
        2: hit = (asleep === 1'b0);
        3: hit = (dumpStart === 1'b1);
        default: hit = (dumpFailInd === 1'b1);
      endcase
      if (k > 2000) hang();
    end
  endtask
  ////////////////////////////////////////////////////////////////////////
  initial begin
    core_clk = 1'b0;
    forever #4 core_clk = ~core_clk;
  end
  initial begin
    reset = 1'b1;
    hsel = 1'b0;
    haddr = 32'h0000_0000;
    htrans = 2'h0;
    hwrite = 1'b0;
    hwdata = 32'h0000_0000;
    keyPress = 1'b0;
    printerReady = 1'b1;
    txRawWord = 32'h0000_0003;
    repeat (3) @(posedge core_clk);
    reset <= 1'b0;
    rchk(AWTC_OFF_TRIGM, 32'hFFFFFFFF, 32'h0000_0003);
    rchk(AWTC_OFF_WORD_FILTER_KEY, 32'hFFFFFFFF, 32'h0000_0C00);
    rchk(AWTC_OFF_TRIGL, 32'hFFFFFFFF, 32'h0000_0300);
    rchk(8'h40, 32'hFFFFFFFF, 32'h0000_0004);
    wr(8'h40, 32'h0000_0003);
    rchk(8'h40, 32'hFFFFFFFF, 32'h0000_0004);
    wr(8'h80, 32'hFFFFFFFF);
    rchk(8'h80, 32'hFFFFFFFF, 32'h0000_0000);
    $display("test reset finished");
    wr(AWTC_OFF_CTRL, 32'h0000_0001);
    wr(AWTC_OFF_WORD_FILTER_KEY, 32'h0000_0820);
    send_n(32'h0000_0020, 1);
    send_n(32'h0000_0021, 1);
    rchk(AWTC_OFF_STAT, 32'h0000_03FF, 32'h0000_0001);
    wr(AWTC_OFF_WORD_FILTER_KEY, 32'h0000_0600);
    send_n(32'h0000_0130, 1);
    send_n(32'h0000_0231, 1);
    rchk(AWTC_OFF_STAT, 32'h0000_03FF, 32'h0000_0002);
    wr(AWTC_OFF_CTRL, 32'h0000_0003);
    rchk(AWTC_OFF_CTRL, 32'hFFFFFFFF, 32'h0000_0001);
    wr(AWTC_OFF_CTRL, 32'h0000_0000);
    send_n(32'h0000_1177, 1);
    send_n(32'h0000_2277, 1);
    rchk(AWTC_OFF_STAT, 32'h0000_03FF, 32'h0000_0003);
    wr(AWTC_OFF_RDIDX, 32'h0000_0020);
    repeat (4100) @(posedge core_clk);
    rchk(AWTC_OFF_DISP, 32'hFFFFFFFF, 32'h0000_0020);
    check({31'h0, parityOdd}, 32'h1);
    $display("test normal and filter finished");
    wr(AWTC_OFF_TRIGL, 32'h0000_0040);
    wr(AWTC_OFF_TRIGD, 32'h0000_0005);
    wr(AWTC_OFF_TRIGM, 32'h0000_0007);
    wr(AWTC_OFF_CTRL, 32'h0000_0002);
    rchk(AWTC_OFF_STAT, 32'h0000_07FF, 32'h0000_0000);
    send_n(32'h0000_0040, 1);
    send_n(32'h0000_0541, 1);
    send_n(32'hABC0_0540, 1);
    send_n(32'h1234_5642, 1);
    rchk(AWTC_OFF_STAT, 32'h0000_07FF, 32'h0000_0402);
    wr(AWTC_OFF_RDIDX, 32'h0000_0000);
    rchk(AWTC_OFF_RDDATA, 32'hFFFFFFFF, 32'hABC0_0540);
    wr(AWTC_OFF_RDIDX, 32'h0000_0001);
    rchk(AWTC_OFF_RDDATA, 32'hFFFFFFFF, 32'h1234_5642);
    printerReady <= 1'b0;
    wr(AWTC_OFF_CMD, 32'h0000_0002);
    wait_for(4, n);
    rchk(AWTC_OFF_STAT, 32'h0000_2000, 32'h0000_2000);
    printerReady <= 1'b1;
    wr(AWTC_OFF_CMD, 32'h0000_0002);
    wait_for(3, n);
    rchk(AWTC_OFF_RDDATA, 32'hFFFFFFFF, 32'h1234_5642);
    $display("test trigger and dump finished");
    wr(AWTC_OFF_CTRL, 32'h0000_0000);
    wr(AWTC_OFF_TRIGL, 32'h0000_0300);
    wr(AWTC_OFF_TFLTL, 32'h0000_0250);
    wr(AWTC_OFF_CTRL, 32'h0000_0002);
    send_n(32'h0000_0051, 1);
    send_n(32'h0000_0150, 2);
    rchk(AWTC_OFF_STAT, 32'h0000_03FF, 32'h0000_0002);
    send_n(32'h0000_0050, 260);
    rchk(AWTC_OFF_STAT, 32'h0000_03FF, 32'h0000_00FF);
    wr(AWTC_OFF_CTRL, 32'h0000_0000);
    wr(AWTC_OFF_TFLTL, 32'h0000_0300);
    wr(AWTC_OFF_CTRL, 32'h0000_0006);
    wr(AWTC_OFF_TFLTL, 32'h0000_0255);
    rchk(AWTC_OFF_CTRL, 32'hFFFFFFFF, 32'h0000_0006);
    send_n(32'h0000_0056, 1);
    send_n(32'h0000_0155, 520);
    rchk(AWTC_OFF_STAT, 32'h0000_03FF, 32'h0000_01FF);
    wr(AWTC_OFF_RDIDX, 32'h0000_0000);
    rchk(AWTC_OFF_RDDATA, 32'hFFFFFFFF, 32'h0000_0100);
    rchk(AWTC_OFF_RDRATE, 32'hFFFFFFFF, 32'h0000_0000);
    wr(AWTC_OFF_CTRL, 32'h0000_0000);
    wr(AWTC_OFF_CTRL, 32'h0000_0002);
    rchk(AWTC_OFF_CTRL, 32'hFFFFFFFF, 32'h0000_0002);
    wr(AWTC_OFF_TFLTL, 32'h0000_0300);
    wr(AWTC_OFF_CTRL, 32'h0000_0006);
    rchk(AWTC_OFF_CTRL, 32'hFFFFFFFF, 32'h0000_0002);
    $display("test trap capacity finished");
    for (int i = 0; i < 2; i++) begin
      wait_for(1, n);
      check({31'h0, asleep}, 32'h1);
      if (i == 0) begin
        keyPress <= 1'b1;
        @(posedge core_clk);
        keyPress <= 1'b0;
      end else begin
        i_uut.send_word(32'h0000_0011);
      end
      wait_for(2, n);
      check({31'h0, n <= 3}, 32'h1);
    end
    $display("test sleep finished");
    wr(AWTC_OFF_CTRL, 32'h0000_0070);
    repeat (3) @(posedge core_clk);
    check({29'h0, txHighSpeed, rxHighSpeed, parityOdd}, 32'h5);
    wr(AWTC_OFF_CTRL, 32'h0000_0048);
    repeat (3) @(posedge core_clk);
    check({29'h0, txHighSpeed, rxHighSpeed, parityOdd}, 32'h2);
    wr(AWTC_OFF_CTRL, 32'h0000_0060);
    wr(AWTC_OFF_SLOTEN, 32'h0000_0201);
    wr(AWTC_OFF_CMD, 32'h0000_0001);
    wait_for(0, n);
    check({txSlot, txWord}, {4'h9, 32'h8000_0003});
    wait_for(0, n);
    check({txSlot, 27'h0, n >= GAP}, {4'h0, 28'h1});
    wr(AWTC_OFF_CTRL, 32'h0000_0040);
    wait_for(0, n);
    check(txWord, 32'h0000_0003);
    $display("test transmit finished");
    tally_and_finish();
  end
endmodule
